/* hw/pin_mux_regs.vh */
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH
// register byte offsets
`define OFS_BUS_CONTROL     12'h000
`define OFS_CLK_OUT_SEL     12'h004
`define OFS_PORTB_PER       12'h008
`define OFS_PORTB_DDR       12'h00C
`define OFS_PORTB_DATA      12'h010
`define OFS_PORTB_PIN       12'h014
`define OFS_PORTF_PER       12'h018
`define OFS_PORTF_DDR       12'h01C
`define OFS_PORTF_DATA      12'h020
`define OFS_PORTF_PULLUP    12'h024
`define OFS_PORTF_PIN       12'h028
`define OFS_BUS_STATUS      12'h02C
// field positions
`define BUS_HOLD_DRIVE_BIT  0
`define PORTF_LO            9
`define PORTF_HI            15
`define PORTB_LO            4
`define PORTB_HI            7
// reset values
`define RST_BUS_CONTROL     1'h0
`define RST_CLK_OUT_SEL     4'h0
`define RST_PORTB_PER       4'h0
`define RST_PORTF_PER       7'h7F
`define RST_PORTF_PULLUP    16'hFE00
`define RST_DDR             7'h00
`define RST_PORTB_DDR       4'h0
`define RST_PORTB_DATA      4'h0
`define RST_PORTF_DATA      7'h00
`endif

/* hw/pin_sync.v */
`timescale 1ns/1ps
// two-flop synchroniser for a bank of pin inputs
module pin_sync #(
   parameter W = 4
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // pins
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // first stage is read only by the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule

/* hw/pad_mux.v */
`timescale 1ns/1ps
// per-pin selection between port control and a peripheral source
module pad_mux #(
   parameter W = 4
) (
   // selection
   input  wire [W-1:0] periph_en,
   // port side
   input  wire [W-1:0] port_oe,
   input  wire [W-1:0] port_out,
   // peripheral side
   input  wire [W-1:0] func_oe,
   input  wire [W-1:0] func_out,
   // pad side
   output wire [W-1:0] pad_oe,
   output wire [W-1:0] pad_out
);
   genvar i;
   // port control ignores every peripheral source
   generate
      for (i = 0; i < W; i = i + 1) begin : g_pin
         assign pad_oe[i]  = periph_en[i] ? func_oe[i]  : port_oe[i];
         assign pad_out[i] = periph_en[i] ? func_out[i] : port_out[i];
      end
   endgenerate
endmodule

/* hw/external_bus_pin_mux.v */
`timescale 1ns/1ps
`include "pin_mux_regs.vh"

// Behaviour
// - Port B pins 4-7 in address function carry upper address bits 20-23.
// - With the bus idle, address lines float or stay driven per the bus hold drive bit.
// - Software should set bus hold drive to one; its reset value is zero.
// - Pins 4-7 can show prescaled, main, second and oscillator clocks.
// - After reset port B pins 4-7 are general purpose.
// - A peripheral enable bit per port B pin releases it from port control.
// - For released port B pins the clock select picks address or clock.
// - Port F pins 9-15 in data mode carry data bits 0-6.
// - With the bus idle, data lines float or stay driven per the bus hold drive bit.
// - Each port F pin under port control is individually input or output.
// - After reset port F pins 9-15 are in data bus mode.
// - A pull-up bit per port F pin at its pin index; clearing it turns the pull-up off.
module external_bus_pin_mux (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // external memory interface core side
   input  wire        bus_active,
   input  wire [3:0]  emi_addr_hi,
   input  wire [6:0]  emi_data_out,
   input  wire        emi_data_write,
   output wire [6:0]  emi_data_in,
   // clock monitor sources, already on pclk
   input  wire        prescaler_clock,
   input  wire        main_system_clock,
   input  wire        second_system_clock,
   input  wire        oscillator_clock,
   // port b pins 4-7
   input  wire [3:0]  portb_pad_in,
   output reg  [3:0]  portb_pad_out,
   output reg  [3:0]  portb_pad_oe,
   // port f pins 9-15
   input  wire [6:0]  portf_pad_in,
   output reg  [6:0]  portf_pad_out,
   output reg  [6:0]  portf_pad_oe,
   output reg  [6:0]  portf_pullup_en,
   // bus hold drive level for the other interface control pins
   output reg         bus_hold_drive
);
   // software state
   reg         bus_hold_drive_q;
   reg  [3:0]  clock_output_select_reg_q;
   reg  [3:0]  port_b_peripheral_enable_q;
   reg  [3:0]  portb_ddr_q;
   reg  [3:0]  portb_data_q;
   reg  [6:0]  portf_per_q;
   reg  [6:0]  portf_ddr_q;
   reg  [6:0]  portf_data_q;
   reg  [15:0] port_f_pullup_enable_q;

   wire [3:0]  portb_sync;
   wire [6:0]  portf_sync;
   wire [3:0]  b_func_out;
   wire [3:0]  b_func_oe;
   wire [6:0]  f_func_oe;
   wire [3:0]  b_mux_out;
   wire [3:0]  b_mux_oe;
   wire [6:0]  f_mux_out;
   wire [6:0]  f_mux_oe;
   wire [3:0]  clk_mon;
   wire        drive_idle;
   wire        wr_en;
   wire        rd_en;
   reg  [31:0] rd_d;
   reg         hit_d;

   // pads come from another domain
   pin_sync #(.W(4)) u_sync_b (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (portb_pad_in),
      .sync_out (portb_sync)
   );

   pin_sync #(.W(7)) u_sync_f (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (portf_pad_in),
      .sync_out (portf_sync)
   );

   assign emi_data_in = portf_sync;

   // clock monitors in pin order 4..7
   assign clk_mon = {oscillator_clock, second_system_clock,
                     main_system_clock, prescaler_clock};

   // idle pins stay driven only with bus hold drive set
   assign drive_idle = bus_active | bus_hold_drive_q;

   // per pin: a set select bit shows the clock monitor and always drives,
   // a clear one carries the address and drives only when the bus allows it
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_bfunc
         assign b_func_out[p] = clock_output_select_reg_q[p] ? clk_mon[p]
                                                             : emi_addr_hi[p];
         assign b_func_oe[p]  = clock_output_select_reg_q[p] | drive_idle;
      end
   endgenerate

   // data pins drive on writes, or hold while idle if asked
   assign f_func_oe = {7{(bus_active & emi_data_write) |
                         (~bus_active & bus_hold_drive_q)}};

   pad_mux #(.W(4)) u_mux_b (
      .periph_en (port_b_peripheral_enable_q),
      .port_oe   (portb_ddr_q),
      .port_out  (portb_data_q),
      .func_oe   (b_func_oe),
      .func_out  (b_func_out),
      .pad_oe    (b_mux_oe),
      .pad_out   (b_mux_out)
   );

   pad_mux #(.W(7)) u_mux_f (
      .periph_en (portf_per_q),
      .port_oe   (portf_ddr_q),
      .port_out  (portf_data_q),
      .func_oe   (f_func_oe),
      .func_out  (emi_data_out),
      .pad_oe    (f_mux_oe),
      .pad_out   (f_mux_out)
   );

   // port b pads registered; one cycle of latency, pins start as inputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portb_pad_out <= 4'h0;
         portb_pad_oe  <= 4'h0;
      end else begin
         portb_pad_out <= b_mux_out;
         portb_pad_oe  <= b_mux_oe;
      end
   end

   // port f pads registered; drivers stay off through reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portf_pad_out <= 7'h00;
         portf_pad_oe  <= 7'h00;
      end else begin
         portf_pad_out <= f_mux_out;
         portf_pad_oe  <= f_mux_oe;
      end
   end

   // pull-ups on from reset so undriven data pins do not float until software clears their pull-up bits
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portf_pullup_en <= 7'h7F;
         bus_hold_drive  <= 1'b0;
      end else begin
         portf_pullup_en <= port_f_pullup_enable_q[`PORTF_HI:`PORTF_LO];
         bus_hold_drive  <= bus_hold_drive_q;
      end
   end

   // apb strobes; a write lands at the edge where pready is seen high,
   // the same edge at which the master lets go of the request
   assign wr_en = psel & penable & pwrite & pready;
   assign rd_en = psel & penable & ~pwrite;

   // bus control; zero after reset, so idle pins float until software
   // asks for them to be held
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_hold_drive_q <= `RST_BUS_CONTROL;
      end else if (wr_en && (paddr == `OFS_BUS_CONTROL)) begin
         bus_hold_drive_q <= pwdata[`BUS_HOLD_DRIVE_BIT];
      end
   end

   // clock output select; a set bit picks the clock monitor for its pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_output_select_reg_q <= `RST_CLK_OUT_SEL;
      end else if (wr_en && (paddr == `OFS_CLK_OUT_SEL)) begin
         clock_output_select_reg_q <= pwdata[`PORTB_HI:`PORTB_LO];
      end
   end

   // port b release bits; every pin starts under port control
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_b_peripheral_enable_q <= `RST_PORTB_PER;
      end else if (wr_en && (paddr == `OFS_PORTB_PER)) begin
         port_b_peripheral_enable_q <= pwdata[`PORTB_HI:`PORTB_LO];
      end
   end

   // port b direction, one bit per pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portb_ddr_q <= `RST_PORTB_DDR;
      end else if (wr_en && (paddr == `OFS_PORTB_DDR)) begin
         portb_ddr_q <= pwdata[`PORTB_HI:`PORTB_LO];
      end
   end

   // port b output levels
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portb_data_q <= `RST_PORTB_DATA;
      end else if (wr_en && (paddr == `OFS_PORTB_DATA)) begin
         portb_data_q <= pwdata[`PORTB_HI:`PORTB_LO];
      end
   end

   // port f release bits; data bus mode from reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portf_per_q <= `RST_PORTF_PER;
      end else if (wr_en && (paddr == `OFS_PORTF_PER)) begin
         portf_per_q <= pwdata[`PORTF_HI:`PORTF_LO];
      end
   end

   // port f direction, one bit per pin
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portf_ddr_q <= `RST_DDR;
      end else if (wr_en && (paddr == `OFS_PORTF_DDR)) begin
         portf_ddr_q <= pwdata[`PORTF_HI:`PORTF_LO];
      end
   end

   // port f output levels
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         portf_data_q <= `RST_PORTF_DATA;
      end else if (wr_en && (paddr == `OFS_PORTF_DATA)) begin
         portf_data_q <= pwdata[`PORTF_HI:`PORTF_LO];
      end
   end

   // port f pull-ups kept at their pin index; low bits always read zero
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_f_pullup_enable_q <= `RST_PORTF_PULLUP;
      end else if (wr_en && (paddr == `OFS_PORTF_PULLUP)) begin
         port_f_pullup_enable_q <= {pwdata[`PORTF_HI:`PORTF_LO], 9'h000};
      end
   end

   // read mux; fields sit at their pin index
   always @* begin
      rd_d  = 32'h0000_0000;
      hit_d = 1'b1;
      case (paddr)
         `OFS_BUS_CONTROL:  rd_d[`BUS_HOLD_DRIVE_BIT] = bus_hold_drive_q;
         `OFS_CLK_OUT_SEL:  rd_d[`PORTB_HI:`PORTB_LO] = clock_output_select_reg_q;
         `OFS_PORTB_PER:    rd_d[`PORTB_HI:`PORTB_LO] = port_b_peripheral_enable_q;
         `OFS_PORTB_DDR:    rd_d[`PORTB_HI:`PORTB_LO] = portb_ddr_q;
         `OFS_PORTB_DATA:   rd_d[`PORTB_HI:`PORTB_LO] = portb_data_q;
         `OFS_PORTB_PIN:    rd_d[`PORTB_HI:`PORTB_LO] = portb_sync;
         `OFS_PORTF_PER:    rd_d[`PORTF_HI:`PORTF_LO] = portf_per_q;
         `OFS_PORTF_DDR:    rd_d[`PORTF_HI:`PORTF_LO] = portf_ddr_q;
         `OFS_PORTF_DATA:   rd_d[`PORTF_HI:`PORTF_LO] = portf_data_q;
         `OFS_PORTF_PULLUP: rd_d[15:0] = port_f_pullup_enable_q;
         `OFS_PORTF_PIN:    rd_d[`PORTF_HI:`PORTF_LO] = portf_sync;
         `OFS_BUS_STATUS:   rd_d[0] = bus_active;
         default:           hit_d = 1'b0;  // unmapped: error, reads zero
      endcase
   end

   // one wait state: pready pulses in the second access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   // error rides with pready for offsets that map to nothing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & penable & ~pready & ~hit_d;
      end
   end

   // read word stands only with pready, zero otherwise so nothing stale lingers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= (rd_en & ~pready) ? rd_d : 32'h0000_0000;
      end
   end
endmodule

/* dv/pin_mux_monitor.sv */
`timescale 1ns/1ps
module pin_mux_monitor (
   // apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // pads and copies
   input wire [6:0]  portf_pad_in,
   input wire [6:0]  emi_data_in,
   input wire        bus_hold_drive,
   input wire [6:0]  portf_pullup_en
);
   reg [1:0] up_q;
   // cycles since reset, so the sync check skips flops still empty
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) up_q <= 2'h0;
      else if (up_q != 2'h3) up_q <= up_q + 2'h1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("no ready");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
   chk_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
   chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
   chk_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
   chk_sync_delay: assert property (up_q == 2'h3 |-> emi_data_in == $past(portf_pad_in, 2))
      else $error("data input delay");
   chk_hold_write: assert property ($changed(bus_hold_drive)
      |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
      else $error("hold changed alone");
   chk_pullup_write: assert property ($changed(portf_pullup_en)
      |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
      else $error("pullup changed alone");
endmodule
bind external_bus_pin_mux pin_mux_monitor i_pin_mux_monitor (.pclk, .presetn, .psel, .penable,
   .pwrite, .prdata, .pready, .pslverr, .portf_pad_in, .emi_data_in, .bus_hold_drive,
   .portf_pullup_en);

/* dv/ext_mem_model.sv */
`timescale 1ns/1ps
module ext_mem_model #(parameter W = 7) (
   // clock
   input  wire         pclk,
   // device pad side
   input  wire [W-1:0] pad_out,
   input  wire [W-1:0] pad_oe,
   input  wire [W-1:0] pull_en,
   // memory side
   input  wire         mem_drive,
   input  wire [W-1:0] mem_data,
   // resolved wire
   output wire [W-1:0] pad_in
);
   reg [W-1:0] float_q = {W{1'b0}};
   // a floating line toggles so no stale level passes for data
   always @(posedge pclk) begin
      float_q <= ~float_q;
   end
   // device first, then memory, then pull-up
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & (mem_drive ? mem_data : pull_en | float_q));
endmodule

/* dv/external_bus_pin_mux_test.sv */
`timescale 1ns/1ps
`include "pin_mux_regs.vh"
module external_bus_pin_mux_test;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire        pready, pslverr, bus_hold_drive;
   reg         bus_active = 1'b0;
   reg         emi_data_write = 1'b0;
   reg         mem_drive = 1'b0;
   reg  [3:0]  emi_addr_hi = 4'h0;
   reg  [3:0]  clk_src = 4'h6;
   reg  [6:0]  emi_data_out = 7'h00;
   reg  [6:0]  mem_data = 7'h00;
   wire [6:0]  emi_data_in, portf_pad_in, portf_pad_out, portf_pad_oe, portf_pullup_en;
   wire [3:0]  portb_pad_in, portb_pad_out, portb_pad_oe;
   integer     err_total = 0;
   integer     n_compared = 0;
   reg  [31:0] rd;
   reg         er;
   // clock
   initial begin
      forever #10 pclk = ~pclk;
   end
   external_bus_pin_mux i_external_bus_pin_mux (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_active, .emi_addr_hi, .emi_data_out,
      .emi_data_write, .emi_data_in, .prescaler_clock(clk_src[0]),
      .main_system_clock(clk_src[1]), .second_system_clock(clk_src[2]),
      .oscillator_clock(clk_src[3]), .portb_pad_in, .portb_pad_out, .portb_pad_oe,
      .portf_pad_in, .portf_pad_out, .portf_pad_oe, .portf_pullup_en, .bus_hold_drive);
   ext_mem_model i_ext_mem_model (.pclk, .pad_out(portf_pad_out), .pad_oe(portf_pad_oe),
      .pull_en(portf_pullup_en), .mem_drive, .mem_data, .pad_in(portf_pad_in));
   ext_mem_model #(.W(4)) i_ext_mem_model_b (.pclk, .pad_out(portb_pad_out),
      .pad_oe(portb_pad_oe), .pull_en(4'hF), .mem_drive(1'b0), .mem_data(4'h0),
      .pad_in(portb_pad_in));
   task finish_test;
      begin
         $display("compared %0d mismatches %0d", n_compared, err_total);
         if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // one apb transfer; answer taken at the rising edge where pready is high
   task apb(input w, input [11:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge pclk);
            n = n + 1;
         end while (pready !== 1'b1 && n < 20);
         if (n >= 20) begin
            chk("pready", 32'h1, pready);
            finish_test;
         end
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdc(input string nm, input [11:0] a, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, exp, rd);
      end
   endtask
   task settle;
      repeat (4) @(negedge pclk);
   endtask
   task t_reset;
      begin
         rdc("bcr", `OFS_BUS_CONTROL, 32'h0);
         rdc("per_b", `OFS_PORTB_PER, 32'h0);
         rdc("per_f", `OFS_PORTF_PER, 32'hFE00);
         rdc("pull_f", `OFS_PORTF_PULLUP, 32'hFE00);
         chk("oe_b", 32'h0, portb_pad_oe);
         chk("oe_f", 32'h0, portf_pad_oe);
         chk("pullup", 32'h7F, portf_pullup_en);
         rdc("unmapped", 12'h030, 32'h0);
         chk("slverr_r", 32'h1, er);
         apb(1'b1, 12'h030, 32'hFFFFFFFF);
         chk("slverr_w", 32'h1, er);
         $display("t_reset done");
      end
   endtask
   task t_gpio_b;
      begin
         apb(1'b1, `OFS_PORTB_DDR, 32'hF0);
         apb(1'b1, `OFS_PORTB_DATA, 32'hA0);
         bus_active <= 1'b1;
         emi_addr_hi <= 4'h5;
         settle;
         chk("oe_b", 32'hF, portb_pad_oe);
         chk("out_b", 32'hA, portb_pad_out);
         rdc("pin_b", `OFS_PORTB_PIN, 32'hA0);
         apb(1'b1, `OFS_PORTB_PER, 32'h10);
         settle;
         chk("out_b", 32'hB, portb_pad_out);
         $display("t_gpio_b done");
      end
   endtask
   task t_addr_clk;
      begin
         apb(1'b1, `OFS_PORTB_PER, 32'hF0);
         settle;
         chk("addr_b", 32'h5, portb_pad_out);
         chk("oe_b", 32'hF, portb_pad_oe);
         @(posedge pclk);
         bus_active <= 1'b0;
         settle;
         chk("idle_oe", 32'h0, portb_pad_oe);
         apb(1'b1, `OFS_BUS_CONTROL, 32'h1);
         settle;
         chk("hold_oe", 32'hF, portb_pad_oe);
         chk("hold", 32'h1, bus_hold_drive);
         apb(1'b1, `OFS_CLK_OUT_SEL, 32'h10);
         settle;
         chk("sel_one", 32'h4, portb_pad_out);
         apb(1'b1, `OFS_CLK_OUT_SEL, 32'hF0);
         settle;
         chk("clocks", 32'h6, portb_pad_out);
         $display("t_addr_clk done");
      end
   endtask
   task t_data;
      begin
         @(posedge pclk);
         bus_active <= 1'b1;
         emi_data_write <= 1'b1;
         emi_data_out <= 7'h55;
         settle;
         chk("d_out", 32'h55, portf_pad_out);
         chk("d_oe", 32'h7F, portf_pad_oe);
         @(posedge pclk);
         emi_data_write <= 1'b0;
         mem_drive <= 1'b1;
         mem_data <= 7'h2A;
         settle;
         chk("d_in", 32'h2A, emi_data_in);
         @(posedge pclk);
         bus_active <= 1'b0;
         mem_drive <= 1'b0;
         settle;
         chk("hold_oe", 32'h7F, portf_pad_oe);
         apb(1'b1, `OFS_BUS_CONTROL, 32'h0);
         settle;
         chk("float_oe", 32'h0, portf_pad_oe);
         $display("t_data done");
      end
   endtask
   task t_gpio_f;
      begin
         apb(1'b1, `OFS_PORTF_DDR, 32'hAA00);
         apb(1'b1, `OFS_PORTF_DATA, 32'hFE00);
         apb(1'b1, `OFS_PORTF_PER, 32'h0);
         settle;
         chk("oe_f", 32'h55, portf_pad_oe);
         chk("out_f", 32'h55, portf_pad_out & 7'h55);
         rdc("pin_f", `OFS_PORTF_PIN, 32'hFE00);
         apb(1'b1, `OFS_PORTF_PULLUP, 32'hFC00);
         settle;
         chk("pullup", 32'h7E, portf_pullup_en);
         $display("t_gpio_f done");
      end
   endtask
   // reset, then the scenarios in order
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_gpio_b;
      t_addr_clk;
      t_data;
      t_gpio_f;
      finish_test;
   end
endmodule
